// ==== shared/pmr_pkg.sv ====
// constants, types and command codes of the identity, trim and margin command block
// assumes a 125 MHz device clock and a slow PMBus clock sampled by it
package pmr_pkg;
  // command codes answered by this block
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_DEV_ID = 8'hAD;
  localparam logic [7:0] CMD_DEV_REV = 8'hAE;
  localparam logic [7:0] CMD_SCRATCH = 8'hD0;
  localparam logic [7:0] CMD_TRIM = 8'hD4;
  localparam logic [7:0] CMD_MARGIN_UP = 8'hD5;
  // linear mode, exponent -9 (1.953 mV per count)
  localparam logic [7:0] VOUT_MODE_VALUE = 8'h17;
  localparam logic [7:0] BLOCK_COUNT = 8'h02;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // register reset and limit values
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [15:0] SCRATCH_WR_MASK = 16'h00FF;
  localparam logic [15:0] TRIM_RESET = 16'h0000;
  localparam logic [15:0] TRIM_MIN = 16'hFFC0;
  localparam logic [15:0] TRIM_MAX = 16'h003F;
  localparam logic [15:0] MARGIN_MIN = 16'h0000;
  localparam logic [15:0] MARGIN_MAX = 16'h001F;
  localparam logic [15:0] MARGIN_RESTORE_LO = 16'h0009;
  localparam logic [15:0] MARGIN_RESTORE_HI = 16'h000F;
  // serial bit positions
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  typedef enum logic [2:0] {
    RAMP_OFF, RAMP_SOFT_START, RAMP_STEADY, RAMP_TOFF_DELAY, RAMP_SOFT_STOP
  } pmr_ramp_type;
  typedef enum logic [2:0] {SMB_IDLE, SMB_ADDR, SMB_RX, SMB_TX, SMB_WAIT} pmr_smb_type;
endpackage

// ==== logic/pmr_smb_target.sv ====
`timescale 1ns/1ps
// byte-level PMBus target: start/stop detection, address match, byte shift and ack
// assumes scl and sda arrive from pins and the bus clock is far slower than mclk_i
module pmr_smb_target
  import pmr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [6:0] dev_addr_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic start_o,
  output logic stop_o,
  output logic wr_byte_o,
  output logic [7:0] wr_data_o,
  input wire logic ack_i,
  output logic rd_next_o,
  input wire logic [7:0] tx_data_i
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d, sda_d;
  pmr_smb_type state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shift, next_shift;
  logic oe, next_oe;
  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

  // only the second stage and its delayed copy are looked at
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
  assign sda_o = 1'b0; // open drain: only ever pulls low
  assign sda_oe_o = oe;
  assign wr_data_o = shift;

  // bus state machine; bytes are judged on the falling edge after the eighth bit
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_oe = oe;
    start_o = 1'b0;
    stop_o = 1'b0;
    wr_byte_o = 1'b0;
    rd_next_o = 1'b0;
    if (start_c)
    begin
      next_state = SMB_ADDR;
      next_cnt = 4'h0;
      next_oe = 1'b0;
      start_o = 1'b1;
    end
    else if (stop_c)
    begin
      next_state = SMB_IDLE;
      next_oe = 1'b0;
      stop_o = 1'b1;
    end
    else if (state == SMB_ADDR || state == SMB_RX || state == SMB_TX)
    begin
      if (scl_rise)
      begin
        if (cnt < BIT_ACK)
        begin
          if (state != SMB_TX)
            next_shift = {shift[6:0], sda_s};
          next_cnt = cnt + 4'h1;
        end
        else if (cnt == BIT_ACK)
        begin
          next_cnt = BIT_DONE;
          // a master nack ends the read
          if (state == SMB_TX && sda_s)
            next_state = SMB_WAIT;
          else if (state == SMB_TX)
            rd_next_o = 1'b1;
        end
      end
      else if (scl_fall)
      begin
        case (state)
          SMB_ADDR:
          begin
            if (cnt == BIT_ACK)
            begin
              next_oe = (shift[7:1] == dev_addr_i);
              rd_next_o = (shift[7:1] == dev_addr_i) & shift[0];
              if (shift[7:1] != dev_addr_i)
                next_state = SMB_WAIT;
            end
            else if (cnt == BIT_DONE)
            begin
              next_cnt = 4'h0;
              next_state = shift[0] ? SMB_TX : SMB_RX;
              next_shift = shift[0] ? tx_data_i : shift;
              next_oe = shift[0] & ~tx_data_i[7];
            end
          end
          SMB_RX:
          begin
            if (cnt == BIT_ACK)
            begin
              wr_byte_o = 1'b1;
              next_oe = ack_i;
              if (!ack_i)
                next_state = SMB_WAIT;
            end
            else if (cnt == BIT_DONE)
            begin
              next_cnt = 4'h0;
              next_oe = 1'b0;
            end
          end
          default:
          begin
            // transmit: release for the master ack, then present the next byte
            if (cnt == BIT_ACK)
              next_oe = 1'b0;
            else if (cnt == BIT_DONE)
            begin
              next_cnt = 4'h0;
              next_shift = tx_data_i;
              next_oe = ~tx_data_i[7];
            end
            else if (cnt != 4'h0)
            begin
              next_shift = {shift[6:0], 1'b0};
              next_oe = ~shift[6];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= SMB_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      oe <= 1'b0;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_d <= scl_s;
      sda_d <= sda_s;
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      oe <= next_oe;
    end
  end
endmodule

// ==== logic/pmr_id_trim_margin.sv ====
`timescale 1ns/1ps
// identity, scratch, reference trim and margin-up commands with the reference ramp
// assumes OPERATION, OPTIONS, limits and nonvolatile storage live in neighbouring logic
// Behaviour
// - identity read is a read-only block read: count 2, low byte then high.
// - revision read is a read-only block read, zero for first silicon.
// - scratch word takes writes in low byte only; high byte reads zero.
// - store-all command copies scratch and trim words to nonvolatile storage.
// - trim adds a signed offset of -64 to +63 steps to the reference.
// - trim word is 16-bit two's complement, high byte sign-extends, default zero.
// - out-of-range trim or margin write clamps, flags invalid data and alerts.
// - loop slave refuses trim and margin access with nack, fault and alert.
// - reference ramps at rise, transition or fall rate chosen by state.
// - reference including offsets is limited by maximum and minimum.
// - output voltage format is fixed linear with exponent -9.
// - margin-high selection adds margin offset; low 5 bits, 0 to 31 steps.
// - margin offset is never stored; restores to 9 or 15 by select bit.
module pmr_id_trim_margin
  import pmr_pkg::*;
#(
  parameter logic [15:0] DEVICE_CODE = 16'h5A01, // arbitrary identity value
  parameter logic [15:0] SILICON_REV = 16'h0000
)
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [6:0] dev_addr_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic loop_slave_i,
  input wire logic margin_high_sel_i,
  input wire logic margin_up_restore_select_i,
  input wire pmr_ramp_type ramp_state_i,
  input wire logic [15:0] rise_interval_i,
  input wire logic [15:0] transition_interval_i,
  input wire logic [15:0] fall_interval_i,
  input wire logic [15:0] vout_command_i,
  input wire logic [15:0] vout_min_i,
  input wire logic [15:0] vout_max_i,
  input wire logic [15:0] nvm_scratch_i,
  input wire logic [15:0] nvm_trim_i,
  input wire logic clear_faults_i,
  output logic nvm_store_o,
  output logic [15:0] nvm_scratch_o,
  output logic [15:0] nvm_trim_o,
  output logic smbalert_o,
  output logic cml_status_o,
  output logic invalid_data_o,
  output logic invalid_command_fault_o,
  output logic [15:0] loop_reference_level_o
);
  logic start, stop, wr_byte, rd_next, ack, cmd_ack;
  logic [7:0] wr_data, rd_byte;
  logic [7:0] cmd, next_cmd, tx_data, next_tx, data_lo, next_data_lo, data_hi, next_data_hi;
  logic cmd_ok, next_cmd_ok, loaded, next_loaded, store, next_store;
  logic [1:0] wr_idx, next_wr_idx, rd_idx, next_rd_idx;
  logic [15:0] scratch, next_scratch, trim, next_trim, margin, next_margin;
  logic [15:0] nvm_scratch, next_nvm_scratch, nvm_trim, next_nvm_trim, wr_word;
  logic inv_data, next_inv_data, invalid_command_fault, next_ivc;
  logic [15:0] ref_level, next_ref, target, interval, ramp_cnt, next_ramp_cnt;
  logic hold;
  logic signed [17:0] ref_sum;

  // commands that a loop slave must refuse
  function automatic logic is_offset_cmd(input logic [7:0] c);
    is_offset_cmd = (c == CMD_TRIM) || (c == CMD_MARGIN_UP);
  endfunction

  function automatic logic is_known_cmd(input logic [7:0] c);
    is_known_cmd = (c == CMD_STORE_ALL) || (c == CMD_VOUT_MODE) || (c == CMD_DEV_ID)
      || (c == CMD_DEV_REV) || (c == CMD_SCRATCH) || is_offset_cmd(c);
  endfunction

  // byte idx of a word, low byte first; past the end reads idle
  function automatic logic [7:0] word_byte(input logic [15:0] w, input logic [1:0] idx);
    word_byte = (idx == 2'h0) ? w[7:0] : ((idx == 2'h1) ? w[15:8] : IDLE_BYTE);
  endfunction

  pmr_smb_target u_target (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .dev_addr_i(dev_addr_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .start_o(start),
    .stop_o(stop),
    .wr_byte_o(wr_byte),
    .wr_data_o(wr_data),
    .ack_i(ack),
    .rd_next_o(rd_next),
    .tx_data_i(tx_data)
  );

  // command byte acceptance; data bytes only for writable words, at most two
  assign cmd_ack = is_known_cmd(wr_data) && !(loop_slave_i && is_offset_cmd(wr_data));
  assign ack = (wr_idx == 2'h0) ? cmd_ack
    : (cmd_ok && wr_idx != 2'h3 && (cmd == CMD_SCRATCH || is_offset_cmd(cmd)));
  assign wr_word = {data_hi, data_lo};

  // read data: refused or unknown commands read back as idle bytes
  always_comb
  begin
    rd_byte = IDLE_BYTE;
    if (cmd_ok)
    begin
      case (cmd)
        CMD_VOUT_MODE: rd_byte = (rd_idx == 2'h0) ? VOUT_MODE_VALUE : IDLE_BYTE;
        CMD_DEV_ID: rd_byte = (rd_idx == 2'h0) ? BLOCK_COUNT
          : word_byte(DEVICE_CODE, rd_idx - 2'h1);
        CMD_DEV_REV: rd_byte = (rd_idx == 2'h0) ? BLOCK_COUNT
          : word_byte(SILICON_REV, rd_idx - 2'h1);
        CMD_SCRATCH: rd_byte = word_byte(scratch, rd_idx);
        CMD_TRIM: rd_byte = word_byte(trim, rd_idx);
        CMD_MARGIN_UP: rd_byte = word_byte(margin, rd_idx);
        default: rd_byte = IDLE_BYTE;
      endcase
    end
  end

  // transaction tracking, register commits and sticky faults
  always_comb
  begin
    next_cmd = cmd;
    next_cmd_ok = cmd_ok;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_data_lo = data_lo;
    next_data_hi = data_hi;
    next_tx = tx_data;
    next_scratch = scratch;
    next_trim = trim;
    next_margin = margin;
    next_loaded = 1'b1;
    next_store = 1'b0;
    next_nvm_scratch = nvm_scratch;
    next_nvm_trim = nvm_trim;
    next_inv_data = inv_data;
    next_ivc = invalid_command_fault;
    // clear first so that a fault raised in the same cycle still lands
    if (clear_faults_i)
    begin
      next_inv_data = 1'b0;
      next_ivc = 1'b0;
    end
    // one power-up load; the margin word is rebuilt, never read back from storage
    if (!loaded)
    begin
      next_scratch = nvm_scratch_i & SCRATCH_WR_MASK;
      next_trim = nvm_trim_i;
      next_margin = margin_up_restore_select_i ? MARGIN_RESTORE_HI : MARGIN_RESTORE_LO;
    end
    if (start)
    begin
      next_wr_idx = 2'h0;
      next_rd_idx = 2'h0;
    end
    if (wr_byte)
    begin
      case (wr_idx)
        2'h0:
        begin
          next_cmd = wr_data;
          next_cmd_ok = cmd_ack;
          if (loop_slave_i && is_offset_cmd(wr_data))
            next_ivc = 1'b1;
        end
        2'h1: next_data_lo = wr_data;
        2'h2: next_data_hi = wr_data;
        default: next_data_hi = data_hi;
      endcase
      if (wr_idx != 2'h3)
        next_wr_idx = wr_idx + 2'h1;
    end
    if (rd_next)
    begin
      next_tx = rd_byte;
      if (rd_idx != 2'h3)
        next_rd_idx = rd_idx + 2'h1;
    end
    if (stop && cmd_ok && loaded)
    begin
      if (wr_idx == 2'h1 && cmd == CMD_STORE_ALL)
      begin
        next_store = 1'b1;
        next_nvm_scratch = scratch;
        next_nvm_trim = trim;
      end
      if (wr_idx == 2'h3)
      begin
        case (cmd)
          CMD_SCRATCH: next_scratch = wr_word & SCRATCH_WR_MASK;
          CMD_TRIM:
          begin
            // the signed compare also catches a high byte that is no sign extension
            if ($signed(wr_word) < $signed(TRIM_MIN))
            begin
              next_trim = TRIM_MIN;
              next_inv_data = 1'b1;
            end
            else if ($signed(wr_word) > $signed(TRIM_MAX))
            begin
              next_trim = TRIM_MAX;
              next_inv_data = 1'b1;
            end
            else
              next_trim = wr_word;
          end
          CMD_MARGIN_UP:
          begin
            if ($signed(wr_word) < $signed(MARGIN_MIN))
            begin
              next_margin = MARGIN_MIN;
              next_inv_data = 1'b1;
            end
            else if ($signed(wr_word) > $signed(MARGIN_MAX))
            begin
              next_margin = MARGIN_MAX;
              next_inv_data = 1'b1;
            end
            else
              next_margin = wr_word & MARGIN_MAX;
          end
          default: next_scratch = scratch;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      cmd <= 8'h00;
      cmd_ok <= 1'b0;
      wr_idx <= 2'h0;
      rd_idx <= 2'h0;
      data_lo <= 8'h00;
      data_hi <= 8'h00;
      tx_data <= IDLE_BYTE;
      scratch <= SCRATCH_RESET;
      trim <= TRIM_RESET;
      margin <= MARGIN_RESTORE_LO;
      loaded <= 1'b0;
      store <= 1'b0;
      nvm_scratch <= SCRATCH_RESET;
      nvm_trim <= TRIM_RESET;
      inv_data <= 1'b0;
      invalid_command_fault <= 1'b0;
    end
    else
    begin
      cmd <= next_cmd;
      cmd_ok <= next_cmd_ok;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      data_lo <= next_data_lo;
      data_hi <= next_data_hi;
      tx_data <= next_tx;
      scratch <= next_scratch;
      trim <= next_trim;
      margin <= next_margin;
      loaded <= next_loaded;
      store <= next_store;
      nvm_scratch <= next_nvm_scratch;
      nvm_trim <= next_nvm_trim;
      inv_data <= next_inv_data;
      invalid_command_fault <= next_ivc;
    end
  end

  assign nvm_store_o = store;
  assign nvm_scratch_o = nvm_scratch;
  assign nvm_trim_o = nvm_trim;
  assign invalid_data_o = inv_data;
  assign invalid_command_fault_o = invalid_command_fault;
  assign cml_status_o = inv_data | invalid_command_fault;
  assign smbalert_o = inv_data | invalid_command_fault;
  assign loop_reference_level_o = ref_level;

  // reference target: command plus trim plus margin when margin-high is selected, held inside min and max
  always_comb
  begin
    ref_sum = $signed({2'b00, vout_command_i}) + $signed({{2{trim[15]}}, trim})
      + $signed({2'b00, (margin_high_sel_i ? margin : 16'h0000)});
    if (ref_sum < $signed({2'b00, vout_min_i}))
      target = vout_min_i;
    else if (ref_sum > $signed({2'b00, vout_max_i}))
      target = vout_max_i;
    else
      target = ref_sum[15:0];
  end

  // ramp one count per interval; the interval is picked by the sequencing state
  always_comb
  begin
    hold = 1'b0;
    case (ramp_state_i)
      RAMP_SOFT_START: interval = rise_interval_i;
      RAMP_STEADY, RAMP_TOFF_DELAY: interval = transition_interval_i;
      RAMP_SOFT_STOP: interval = fall_interval_i;
      default:
      begin
        interval = 16'h0000;
        hold = 1'b1;
      end
    endcase
    next_ramp_cnt = ramp_cnt + 16'h0001;
    next_ref = ref_level;
    if (hold || ref_level == target)
      next_ramp_cnt = 16'h0000;
    else if (next_ramp_cnt >= interval)
    begin
      // an interval of zero behaves as one count per clock
      next_ramp_cnt = 16'h0000;
      next_ref = (ref_level < target) ? ref_level + 16'h0001 : ref_level - 16'h0001;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      ramp_cnt <= 16'h0000;
      ref_level <= 16'h0000;
    end
    else
    begin
      ramp_cnt <= next_ramp_cnt;
      ref_level <= next_ref;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_trim_high_write;
    stop && cmd_ok && loaded && cmd == CMD_TRIM && wr_idx == 2'h3
      && $signed(wr_word) > $signed(TRIM_MAX);
  endsequence

  a_block_count_first: assert property (rd_next && cmd_ok && cmd == CMD_DEV_ID
    && rd_idx == 2'h0 |=> tx_data == BLOCK_COUNT ##0 rd_idx == 2'h1)
    else $error("identity block count not sent first");
  a_rev_low_byte: assert property (rd_next && cmd_ok && cmd == CMD_DEV_REV
    && rd_idx == 2'h1 |=> tx_data == SILICON_REV[7:0])
    else $error("revision low byte wrong");
  a_scratch_high_zero: assert property (scratch[15:8] == 8'h00)
    else $error("scratch high byte not zero");
  a_store_copies_words: assert property (
    stop && cmd_ok && loaded && cmd == CMD_STORE_ALL && wr_idx == 2'h1
    |=> nvm_store_o && nvm_trim_o == $past(trim) && nvm_scratch_o == $past(scratch) ##1 !nvm_store_o)
    else $error("store command did not copy words");
  a_trim_in_range: assert property (loaded |-> $signed(trim) >= $signed(TRIM_MIN)
    && $signed(trim) <= $signed(TRIM_MAX))
    else $error("trim word outside range");
  a_trim_clamp_flag: assert property (s_trim_high_write |=> trim == TRIM_MAX
    && invalid_data_o && smbalert_o && cml_status_o)
    else $error("out of range trim not clamped and flagged");
  a_slave_refusal: assert property (wr_byte && wr_idx == 2'h0 && loop_slave_i
    && is_offset_cmd(wr_data) |-> !ack ##1 invalid_command_fault_o && smbalert_o && !cmd_ok)
    else $error("loop slave access not refused");
  a_ramp_hold_off: assert property (ramp_state_i == RAMP_OFF [*2] |-> $stable(ref_level))
    else $error("reference moved while off");
  a_ramp_one_step: assert property (ref_level != $past(ref_level)
    |-> ref_level == $past(ref_level) + 16'h0001 || ref_level == $past(ref_level) - 16'h0001)
    else $error("reference jumped by more than one count");
  a_target_limits: assert property (vout_min_i <= vout_max_i
    |-> target >= vout_min_i && target <= vout_max_i)
    else $error("reference target outside limits");
  a_margin_upper_zero: assert property (margin[15:5] == 11'h000)
    else $error("margin upper bits not zero");
  a_margin_restore: assert property (!loaded ##1 loaded |->
    margin == ($past(margin_up_restore_select_i) ? MARGIN_RESTORE_HI : MARGIN_RESTORE_LO))
    else $error("margin restore value wrong");
endmodule

// ==== verification/pmr_host_model.sv ====
`timescale 1ns/1ps
// PMBus host model: bit-level controller tasks on an open-drain data line
// assumes the bench resolves sda_i from all parties with a pull-up
module pmr_host_model
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  localparam logic [6:0] ADDR = 7'h2A;
  // clock stands high and data is released outside frames
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic t(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // data moves only while scl is low, so no false start or stop appears
  task automatic bit_io(input logic o, output logic i);
    sda_low_o = ~o;
    t(5);
    scl_o = 1'b1;
    t(10);
    i = sda_i;
    scl_o = 1'b0;
    t(5);
  endtask
  task automatic start;
    sda_low_o = 1'b0;
    t(5);
    scl_o = 1'b1;
    t(5);
    sda_low_o = 1'b1;
    t(5);
    scl_o = 1'b0;
    t(5);
  endtask
  task automatic stop;
    sda_low_o = 1'b1;
    t(5);
    scl_o = 1'b1;
    t(5);
    sda_low_o = 1'b0;
    t(20);
  endtask
  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], x);
    bit_io(1'b1, x);
    ack = ~x;
  endtask
  task automatic byte_in(input logic last, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, x);
  endtask
  // word write, low byte first; n data bytes (0 gives a send-byte)
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n,
    output logic [3:0] ack);
    ack = 4'h0;
    start();
    byte_out({ADDR, 1'b0}, ack[0]);
    byte_out(cmd, ack[1]);
    if (n > 0)
      byte_out(d[7:0], ack[2]);
    if (n > 1)
      byte_out(d[15:8], ack[3]);
    stop();
  endtask
  // read of n bytes after a repeated start; last byte is not acknowledged
  task automatic rd(input logic [7:0] cmd, input int n, output logic [31:0] d,
    output logic ack);
    logic a;
    d = 32'h0;
    start();
    byte_out({ADDR, 1'b0}, a);
    byte_out(cmd, ack);
    start();
    byte_out({ADDR, 1'b1}, a);
    for (int k = 0; k < n; k++)
      byte_in(k == n - 1, d[8*k+:8]);
    stop();
  endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
// self-checking bench of the identity, trim and margin command block
// assumes the host model is the only bus master; the pull-up is modelled here
module tb_top;
  import pmr_pkg::*;
  localparam logic [15:0] CODE = 16'h3C96; // arbitrary identity value
  localparam logic [15:0] REV = 16'h0002;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, slave = 1'b0, msel = 1'b0, clr = 1'b0, rsel = 1'b0;
  logic [15:0] vmin = 16'h0000, vcmd = 16'h0064, nvt = 16'h0000;
  logic scl, host_low, sda_o, sda_oe_o, st_o, alert, cml, inv_d, inv_c;
  logic [15:0] rise = 16'h1, trans = 16'h1, fall = 16'h1, vmax = 16'hFFFF, ref_o, sc_o, tr_o;
  logic [31:0] snap = 32'h0;
  pmr_ramp_type ramp = RAMP_STEADY;
  int err_total = 0, check_count = 0, stores = 0;
  pmr_id_trim_margin #(.DEVICE_CODE(CODE), .SILICON_REV(REV)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .dev_addr_i(7'h2A), .scl_i(scl),
    .sda_i(~(sda_oe_o | host_low)), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .loop_slave_i(slave), .margin_high_sel_i(msel), .margin_up_restore_select_i(rsel),
    .ramp_state_i(ramp), .rise_interval_i(rise), .transition_interval_i(trans),
    .fall_interval_i(fall), .vout_command_i(vcmd), .vout_min_i(vmin),
    .vout_max_i(vmax), .nvm_scratch_i(16'hAB12), .nvm_trim_i(nvt),
    .clear_faults_i(clr), .nvm_store_o(st_o), .nvm_scratch_o(sc_o), .nvm_trim_o(tr_o),
    .smbalert_o(alert), .cml_status_o(cml), .invalid_data_o(inv_d),
    .invalid_command_fault_o(inv_c), .loop_reference_level_o(ref_o));
  pmr_host_model h (.clk_i(mclk_i), .sda_i(~(sda_oe_o | host_low)), .scl_o(scl),
    .sda_low_o(host_low));
  always #4 mclk_i = ~mclk_i;
  // the store pulse lasts one cycle; looked at on the falling edge, away from its launch
  always @(negedge mclk_i)
    if (st_o === 1'b1)
    begin
      stores++;
      snap = {sc_o, tr_o};
    end
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for the ramped reference; a hang ends the run
  task automatic wait_ref(input logic [15:0] exp, output int n);
    n = 0;
    while (ref_o !== exp && n < 3000)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(ref_o, exp);
    if (n >= 3000)
      results();
  endtask
  task automatic clear;
    clr = 1'b1;
    @(posedge mclk_i);
    #1 clr = 1'b0;
    h.t(2);
    chk({inv_d, inv_c, cml, alert}, 4'h0);
  endtask
  task automatic t_id;
    logic [31:0] d;
    logic a;
    logic [3:0] k;
    h.rd(CMD_DEV_ID, 3, d, a);
    chk(d, {8'h0, CODE, BLOCK_COUNT});
    h.rd(CMD_DEV_REV, 3, d, a);
    chk(d, {8'h0, REV, BLOCK_COUNT});
    h.wr(CMD_DEV_ID, 16'h1234, 2, k);
    chk({sda_o, k[2]}, 2'h0);
    h.rd(CMD_VOUT_MODE, 1, d, a);
    chk(d, VOUT_MODE_VALUE);
    h.rd(CMD_MARGIN_UP, 2, d, a);
    chk(d, MARGIN_RESTORE_LO);
    h.rd(CMD_SCRATCH, 2, d, a);
    chk(d, 16'h0012);
    h.wr(CMD_SCRATCH, 16'hFFA5, 2, k);
    h.rd(CMD_SCRATCH, 2, d, a);
    chk(d, 16'h00A5);
    $display("test id and scratch done");
  endtask
  task automatic t_trim;
    logic [31:0] d;
    logic a;
    logic [3:0] k;
    int n;
    h.wr(CMD_TRIM, 16'h0005, 2, k);
    h.rd(CMD_TRIM, 2, d, a);
    chk(d, 16'h0005);
    wait_ref(16'h0069, n);
    h.wr(CMD_TRIM, 16'h0080, 2, k);
    h.rd(CMD_TRIM, 2, d, a);
    chk({inv_d, cml, alert, d[15:0]}, {3'h7, TRIM_MAX});
    clear();
    h.wr(CMD_TRIM, 16'hFF00, 2, k);
    h.rd(CMD_TRIM, 2, d, a);
    chk({inv_d, alert, d[15:0]}, {2'h3, TRIM_MIN});
    wait_ref(16'h0024, n);
    clear();
    h.wr(CMD_MARGIN_UP, 16'h00FF, 2, k);
    h.rd(CMD_MARGIN_UP, 2, d, a);
    chk({inv_d, alert, d[15:0]}, {2'h3, MARGIN_MAX});
    clear();
    h.wr(CMD_TRIM, 16'h0000, 2, k);
    h.wr(CMD_MARGIN_UP, 16'h0003, 2, k);
    msel = 1'b1;
    wait_ref(16'h0067, n);
    $display("test trim and margin done");
  endtask
  task automatic t_store_slave;
    logic [31:0] d;
    logic a;
    logic [3:0] k;
    h.wr(CMD_SCRATCH, 16'h005C, 2, k);
    h.wr(CMD_TRIM, 16'h0007, 2, k);
    h.wr(CMD_STORE_ALL, 16'h0, 0, k);
    h.t(4);
    chk(stores, 1);
    chk(snap, 32'h005C_0007);
    slave = 1'b1;
    h.wr(CMD_TRIM, 16'h0010, 2, k);
    chk({k[1], inv_c, alert}, 3'h3);
    h.rd(CMD_MARGIN_UP, 2, d, a);
    chk(a, 1'b0);
    slave = 1'b0;
    h.rd(CMD_TRIM, 2, d, a);
    chk(d, 16'h0007);
    clear();
    h.wr(CMD_TRIM, 16'h0000, 2, k);
    $display("test store and loop slave done");
  endtask
  // the soft-start, steady and soft-stop states must step at their own intervals: 4, 6 and 8 clocks per count
  task automatic t_ramp;
    pmr_ramp_type st[3] = '{RAMP_SOFT_START, RAMP_STEADY, RAMP_SOFT_STOP};
    int n;
    int iv;
    rise = 16'h4;
    trans = 16'h6;
    fall = 16'h8;
    for (int i = 0; i < 3; i++)
    begin
      iv = 4 + 2 * i;
      ramp = st[i];
      msel = (i == 1);
      wait_ref(msel ? 16'h0067 : 16'h0064, n);
      chk(n >= 2 * iv && n <= 3 * iv + 3, 1'b1);
    end
    ramp = RAMP_OFF;
    msel = 1'b1;
    h.t(40);
    chk(ref_o, 16'h0064);
    ramp = RAMP_STEADY;
    vmax = 16'h0050;
    wait_ref(16'h0050, n);
    vmax = 16'hFFFF;
    vmin = 16'h0058;
    vcmd = 16'h0040;
    wait_ref(16'h0058, n);
    $display("test ramp and limits done");
  endtask
  // second reset in mid-run: other restore select and a stored trim word
  task automatic t_reload;
    logic [31:0] d;
    logic a;
    rsel = 1'b1;
    nvt = 16'hFFF0;
    rst_b_i = 1'b0;
    h.t(4);
    rst_b_i = 1'b1;
    h.t(4);
    h.rd(CMD_MARGIN_UP, 2, d, a);
    chk(d, MARGIN_RESTORE_HI);
    h.rd(CMD_TRIM, 2, d, a);
    chk(d, 16'hFFF0);
    $display("test reload done");
  endtask
  initial
  begin
    repeat (8) @(posedge mclk_i);
    #1 rst_b_i = 1'b1;
    h.t(4);
    t_id();
    t_trim();
    t_store_slave();
    t_ramp();
    t_reload();
    results();
  end
endmodule
